// *** core/abort_response.sv ***
// Answer policy for master aborts on PCI and unsupported requests from PCI Express.
// Pure logic; the caller registers every result.
`default_nettype none

module abort_response (
    input wire logic abort_mode,
    input wire logic ma_read,
    input wire logic ma_posted,
    input wire logic ur_read,
    output logic [2:0] cpl_status,
    output logic [31:0] cpl_data,
    output logic cpl_send,
    output logic posted_err,
    output logic target_abort,
    output logic [31:0] pci_data
);

    // ==========================================================
    // Policy
    // Posted writes never get a completion; only the error flag may show them
    always_comb begin
        cpl_send = !ma_posted;
        cpl_status = abort_mode ? bridge_pkg::CPL_UR : bridge_pkg::CPL_SC; // see R1, see R2
        cpl_data = (!abort_mode && ma_read) ? bridge_pkg::ALL_ONES : 32'h0000_0000; // see R1
        posted_err = abort_mode && ma_posted; // see R4
        target_abort = abort_mode; // see R3
        pci_data = (!abort_mode && ur_read) ? bridge_pkg::ALL_ONES : 32'h0000_0000; // see R1
    end

endmodule // abort_response

`default_nettype wire

// *** core/bridge_abort_ctrl.sv ***
// Bridge abort answers and legacy display forwarding, with AHB-Lite registers.
// Assumes request strobes come from logic on hclk; one single-word bus master.
//
// Summary of operation
// R1: Mode zero: reads give all ones, writes dropped
// R2: Mode one: PCI master abort answers unsupported
// R3: Mode one: unsupported completion gives target abort
// R4: Mode one flags posted write master aborts
// R5: Full decode matters only with forwarding on
// R6: Full decode checks bits 15 to 10
// R7: Forward legacy display memory range downstream
// R8: Forward legacy display I/O ranges, aliases allowed
// R9: Block legacy display addresses going upstream
// R10: Ignore ISA bit and windows for legacy
// R11: Command enables qualify legacy forwarding
// R12: Forwarding off: only windows decide downstream
// R13: Settings apply to transactions starting later
`default_nettype none

module bridge_abort_ctrl (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    input wire logic pri_req_valid,
    input wire logic pri_req_io,
    input wire logic [31:0] pri_req_addr,
    output logic pri_fwd_valid,
    output logic pri_fwd_claim,
    input wire logic sec_req_valid,
    input wire logic sec_req_io,
    input wire logic [31:0] sec_req_addr,
    output logic sec_fwd_valid,
    output logic sec_fwd_up,
    input wire logic ma_valid,
    input wire logic ma_read,
    input wire logic ma_posted,
    output logic cpl_valid,
    output logic [2:0] cpl_status,
    output logic [31:0] cpl_data,
    output logic posted_err,
    input wire logic ur_valid,
    input wire logic ur_read,
    output logic pci_term_valid,
    output logic pci_target_abort,
    output logic [31:0] pci_rdata,
    output logic irq
);

    // ==========================================================
    // Register state
    logic [15:0] ctrl_q, ctrl_d;
    logic [1:0] cmd_q, cmd_d;
    logic [31:0] io_base_q, io_base_d, io_limit_q, io_limit_d;
    logic [31:0] mem_base_q, mem_base_d, mem_limit_q, mem_limit_d;
    logic [31:0] pref_base_q, pref_base_d, pref_limit_q, pref_limit_d;
    logic [2:0] stat_q, stat_d, mask_q, mask_d;
    logic irq_q, irq_d;
    logic [31:0] hrdata_q, hrdata_d;
    logic dp_wr_q, dp_wr_d;
    logic [7:0] dp_addr_q, dp_addr_d;
    logic addr_phase;
    logic [2:0] events;

    // Control bits as seen by the datapath
    logic abort_mode, full_io, fwd_en, io_en, mem_en;
    assign abort_mode = ctrl_q[bridge_pkg::CTRL_ABORT_MODE];
    assign full_io = ctrl_q[bridge_pkg::CTRL_FULL_IO];
    assign fwd_en = ctrl_q[bridge_pkg::CTRL_FWD_EN];
    assign io_en = cmd_q[bridge_pkg::CMD_IO_EN];
    assign mem_en = cmd_q[bridge_pkg::CMD_MEM_EN];

    // ==========================================================
    // Bus slave: zero wait state, always OKAY
    // Read data is muxed in the address phase so it stands in the data phase
    always_comb begin
        addr_phase = hsel && hready && htrans[1];
        dp_wr_d = addr_phase && hwrite && (hsize == bridge_pkg::HSIZE_WORD);
        dp_addr_d = addr_phase ? haddr[7:0] : dp_addr_q;
        hrdata_d = hrdata_q;
        if (addr_phase && !hwrite) begin
            case (haddr[7:0])
                bridge_pkg::OFS_CTRL: hrdata_d = {16'h0000, ctrl_q};
                bridge_pkg::OFS_CMD: hrdata_d = {30'h0000_0000, cmd_q};
                bridge_pkg::OFS_IO_BASE: hrdata_d = io_base_q;
                bridge_pkg::OFS_IO_LIMIT: hrdata_d = io_limit_q;
                bridge_pkg::OFS_MEM_BASE: hrdata_d = mem_base_q;
                bridge_pkg::OFS_MEM_LIMIT: hrdata_d = mem_limit_q;
                bridge_pkg::OFS_PREF_BASE: hrdata_d = pref_base_q;
                bridge_pkg::OFS_PREF_LIMIT: hrdata_d = pref_limit_q;
                bridge_pkg::OFS_IRQ_STAT: hrdata_d = {29'h0000_0000, stat_q};
                bridge_pkg::OFS_IRQ_MASK: hrdata_d = {29'h0000_0000, mask_q};
                default: hrdata_d = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata_q <= 32'h0000_0000;
            dp_wr_q <= 1'b0;
            dp_addr_q <= 8'h00;
        end else begin
            hrdata_q <= hrdata_d;
            dp_wr_q <= dp_wr_d;
            dp_addr_q <= dp_addr_d;
        end
    end

    assign hrdata = hrdata_q;
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;

    // ==========================================================
    // Register writes, status set and read clear
    // A new value lands at the end of the data phase, so only
    // requests presented after that edge see it
    always_comb begin
        ctrl_d = ctrl_q;
        cmd_d = cmd_q;
        io_base_d = io_base_q;
        io_limit_d = io_limit_q;
        mem_base_d = mem_base_q;
        mem_limit_d = mem_limit_q;
        pref_base_d = pref_base_q;
        pref_limit_d = pref_limit_q;
        mask_d = mask_q;
        if (dp_wr_q) begin
            case (dp_addr_q)
                bridge_pkg::OFS_CTRL: begin // see R13
                    ctrl_d[bridge_pkg::CTRL_ABORT_MODE] = hwdata[bridge_pkg::CTRL_ABORT_MODE];
                    ctrl_d[bridge_pkg::CTRL_FULL_IO] = hwdata[bridge_pkg::CTRL_FULL_IO];
                    ctrl_d[bridge_pkg::CTRL_FWD_EN] = hwdata[bridge_pkg::CTRL_FWD_EN];
                end
                bridge_pkg::OFS_CMD: cmd_d = hwdata[1:0];
                bridge_pkg::OFS_IO_BASE: io_base_d = hwdata;
                bridge_pkg::OFS_IO_LIMIT: io_limit_d = hwdata;
                bridge_pkg::OFS_MEM_BASE: mem_base_d = hwdata;
                bridge_pkg::OFS_MEM_LIMIT: mem_limit_d = hwdata;
                bridge_pkg::OFS_PREF_BASE: pref_base_d = hwdata;
                bridge_pkg::OFS_PREF_LIMIT: pref_limit_d = hwdata;
                bridge_pkg::OFS_IRQ_MASK: mask_d = hwdata[2:0];
                default: ctrl_d = ctrl_q;
            endcase
        end
        // Clear first, then set, so an event in the read cycle survives
        stat_d = stat_q;
        if (addr_phase && !hwrite && (haddr[7:0] == bridge_pkg::OFS_IRQ_STAT)) begin
            stat_d = bridge_pkg::IRQ_RESET;
        end
        stat_d = stat_d | events;
        irq_d = |(stat_d & mask_d);
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ctrl_q <= bridge_pkg::CTRL_RESET;
            cmd_q <= bridge_pkg::CMD_RESET;
            io_base_q <= bridge_pkg::BASE_RESET;
            io_limit_q <= bridge_pkg::LIMIT_RESET;
            mem_base_q <= bridge_pkg::BASE_RESET;
            mem_limit_q <= bridge_pkg::LIMIT_RESET;
            pref_base_q <= bridge_pkg::BASE_RESET;
            pref_limit_q <= bridge_pkg::LIMIT_RESET;
            stat_q <= bridge_pkg::IRQ_RESET;
            mask_q <= bridge_pkg::IRQ_RESET;
            irq_q <= 1'b0;
        end else begin
            ctrl_q <= ctrl_d;
            cmd_q <= cmd_d;
            io_base_q <= io_base_d;
            io_limit_q <= io_limit_d;
            mem_base_q <= mem_base_d;
            mem_limit_q <= mem_limit_d;
            pref_base_q <= pref_base_d;
            pref_limit_q <= pref_limit_d;
            stat_q <= stat_d;
            mask_q <= mask_d;
            irq_q <= irq_d;
        end
    end

    assign irq = irq_q;

    // ==========================================================
    // Address decode for both sides
    logic pri_mem_hit, pri_io_hit, sec_mem_hit, sec_io_hit;
    logic vga_full;

    // Full decode is forced off unless forwarding is on
    assign vga_full = fwd_en && full_io; // see R5

    legacy_display_decode u_pri_dec (
        .addr(pri_req_addr),
        .full_io_decode(vga_full),
        .mem_hit(pri_mem_hit),
        .io_hit(pri_io_hit)
    );

    legacy_display_decode u_sec_dec (
        .addr(sec_req_addr),
        .full_io_decode(vga_full),
        .mem_hit(sec_mem_hit),
        .io_hit(sec_io_hit)
    );

    function automatic logic in_win(input logic [31:0] a, input logic [31:0] b,
                                    input logic [31:0] l);
        in_win = (a >= b) && (a <= l);
    endfunction

    // ==========================================================
    // Forwarding and abort answers
    logic pri_claim_d, sec_up_d, pri_win, sec_win, pri_legacy, sec_legacy;
    logic [2:0] ar_status;
    logic [31:0] ar_cpl_data, ar_pci_data;
    logic ar_send, ar_perr, ar_tabort;
    logic pri_fwd_valid_q, pri_fwd_claim_q, sec_fwd_valid_q, sec_fwd_up_q;
    logic cpl_valid_q, cpl_valid_d, posted_err_q, posted_err_d;
    logic [2:0] cpl_status_q, cpl_status_d;
    logic [31:0] cpl_data_q, cpl_data_d, pci_rdata_q, pci_rdata_d;
    logic pci_term_q, pci_tabort_q, pci_tabort_d;

    abort_response u_abort (
        .abort_mode(abort_mode),
        .ma_read(ma_read),
        .ma_posted(ma_posted),
        .ur_read(ur_read),
        .cpl_status(ar_status),
        .cpl_data(ar_cpl_data),
        .cpl_send(ar_send),
        .posted_err(ar_perr),
        .target_abort(ar_tabort),
        .pci_data(ar_pci_data)
    );

    // Decisions use the settings present in the cycle the request starts
    always_comb begin
        pri_win = pri_req_io ? in_win(pri_req_addr, io_base_q, io_limit_q)
            : (in_win(pri_req_addr, mem_base_q, mem_limit_q)
            || in_win(pri_req_addr, pref_base_q, pref_limit_q)); // see R12
        sec_win = sec_req_io ? in_win(sec_req_addr, io_base_q, io_limit_q)
            : (in_win(sec_req_addr, mem_base_q, mem_limit_q)
            || in_win(sec_req_addr, pref_base_q, pref_limit_q));
        // Legacy match ignores the ISA bit and every window
        pri_legacy = fwd_en && (pri_req_io ? pri_io_hit : pri_mem_hit); // see R7, see R8, see R10
        sec_legacy = fwd_en && (sec_req_io ? sec_io_hit : sec_mem_hit); // see R9
        pri_claim_d = (pri_req_io ? io_en : mem_en) && (pri_win || pri_legacy); // see R11, see R13
        sec_up_d = !sec_win && !sec_legacy; // see R9
        cpl_valid_d = ma_valid && ar_send;
        cpl_status_d = ma_valid ? ar_status : cpl_status_q;
        cpl_data_d = ma_valid ? ar_cpl_data : cpl_data_q;
        posted_err_d = ma_valid && ar_perr; // see R4
        pci_tabort_d = ur_valid ? ar_tabort : pci_tabort_q; // see R3
        pci_rdata_d = ur_valid ? ar_pci_data : pci_rdata_q;
        events = 3'h0;
        events[bridge_pkg::IRQ_POSTED_ERR] = posted_err_d;
        events[bridge_pkg::IRQ_UR_SENT] = cpl_valid_d && abort_mode; // see R2
        events[bridge_pkg::IRQ_TGT_ABORT] = ur_valid && ar_tabort;
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pri_fwd_valid_q <= 1'b0;
            pri_fwd_claim_q <= 1'b0;
            sec_fwd_valid_q <= 1'b0;
            sec_fwd_up_q <= 1'b0;
            cpl_valid_q <= 1'b0;
            cpl_status_q <= bridge_pkg::CPL_SC;
            cpl_data_q <= 32'h0000_0000;
            posted_err_q <= 1'b0;
            pci_term_q <= 1'b0;
            pci_tabort_q <= 1'b0;
            pci_rdata_q <= 32'h0000_0000;
        end else begin
            pri_fwd_valid_q <= pri_req_valid;
            pri_fwd_claim_q <= pri_req_valid && pri_claim_d;
            sec_fwd_valid_q <= sec_req_valid;
            sec_fwd_up_q <= sec_req_valid && sec_up_d;
            cpl_valid_q <= cpl_valid_d;
            cpl_status_q <= cpl_status_d;
            cpl_data_q <= cpl_data_d;
            posted_err_q <= posted_err_d;
            pci_term_q <= ur_valid;
            pci_tabort_q <= pci_tabort_d;
            pci_rdata_q <= pci_rdata_d;
        end
    end

    assign pri_fwd_valid = pri_fwd_valid_q;
    assign pri_fwd_claim = pri_fwd_claim_q;
    assign sec_fwd_valid = sec_fwd_valid_q;
    assign sec_fwd_up = sec_fwd_up_q;
    assign cpl_valid = cpl_valid_q;
    assign cpl_status = cpl_status_q;
    assign cpl_data = cpl_data_q;
    assign posted_err = posted_err_q;
    assign pci_term_valid = pci_term_q;
    assign pci_target_abort = pci_tabort_q;
    assign pci_rdata = pci_rdata_q;

    // ==========================================================
    // Checks
    a_ma_all_ones: assert property (@(posedge hclk) disable iff (!hresetn) // see R1
        ma_valid && ma_read && !ma_posted && !abort_mode
        |=> cpl_valid && cpl_data == 32'hFFFF_FFFF && cpl_status == 3'h0)
        else $error("read master abort did not return all ones");

    a_ma_unsupported: assert property (@(posedge hclk) disable iff (!hresetn) // see R2
        ma_valid && !ma_posted && abort_mode |=> cpl_valid && cpl_status == 3'h1)
        else $error("master abort not answered as unsupported");

    a_ur_tabort: assert property (@(posedge hclk) disable iff (!hresetn) // see R3
        ur_valid |=> pci_term_valid && (pci_target_abort == $past(abort_mode)))
        else $error("target abort does not follow mode");

    a_posted_err_gate: assert property (@(posedge hclk) disable iff (!hresetn) // see R4
        posted_err |-> $past(ma_valid && ma_posted && abort_mode) && !cpl_valid)
        else $error("posted error without cause");

    a_vga_mem_claim: assert property (@(posedge hclk) disable iff (!hresetn) // see R7
        pri_req_valid && !pri_req_io && fwd_en && mem_en
        && pri_req_addr >= 32'h000A_0000 && pri_req_addr <= 32'h000B_FFFF
        |=> pri_fwd_valid && pri_fwd_claim)
        else $error("legacy memory access not claimed");

    a_vga_io_alias: assert property (@(posedge hclk) disable iff (!hresetn) // see R8
        pri_req_valid && pri_req_io && fwd_en && !full_io && io_en
        && pri_req_addr[31:16] == 16'h0000 && pri_req_addr[9:0] == 10'h3C0
        |=> pri_fwd_claim)
        else $error("legacy I/O alias not claimed");

    a_full_decode: assert property (@(posedge hclk) disable iff (!hresetn) // see R6
        pri_req_valid && pri_req_io && fwd_en && full_io && pri_req_addr[15:10] != 6'h00
        && !in_win(pri_req_addr, io_base_q, io_limit_q) |=> !pri_fwd_claim)
        else $error("full decode accepted an alias");

    a_sec_block: assert property (@(posedge hclk) disable iff (!hresetn) // see R9
        sec_req_valid && fwd_en && !sec_req_io && sec_req_addr == 32'h000A_0000
        |=> sec_fwd_valid && !sec_fwd_up)
        else $error("legacy address forwarded upstream");

    a_enable_qual: assert property (@(posedge hclk) disable iff (!hresetn) // see R11
        pri_fwd_claim |-> $past(pri_req_io ? io_en : mem_en))
        else $error("claim without command enable");

endmodule // bridge_abort_ctrl

`default_nettype wire

// *** core/bridge_pkg.sv ***
// Shared constants for the bridge abort-response and legacy display decode block.
// Assumes one 100 MHz clock and a 32-bit AHB-Lite register port.
`default_nettype none

package bridge_pkg;

    // ==========================================================
    // Register byte offsets
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_CMD = 8'h04;
    localparam logic [7:0] OFS_IO_BASE = 8'h08;
    localparam logic [7:0] OFS_IO_LIMIT = 8'h0C;
    localparam logic [7:0] OFS_MEM_BASE = 8'h10;
    localparam logic [7:0] OFS_MEM_LIMIT = 8'h14;
    localparam logic [7:0] OFS_PREF_BASE = 8'h18;
    localparam logic [7:0] OFS_PREF_LIMIT = 8'h1C;
    localparam logic [7:0] OFS_IRQ_STAT = 8'h20;
    localparam logic [7:0] OFS_IRQ_MASK = 8'h24;

    // ==========================================================
    // Field positions
    localparam int unsigned CTRL_ABORT_MODE = 5;
    localparam int unsigned CTRL_FULL_IO = 4;
    localparam int unsigned CTRL_FWD_EN = 3;
    localparam int unsigned CMD_IO_EN = 0;
    localparam int unsigned CMD_MEM_EN = 1;
    localparam int unsigned IRQ_POSTED_ERR = 0;
    localparam int unsigned IRQ_UR_SENT = 1;
    localparam int unsigned IRQ_TGT_ABORT = 2;
    localparam int unsigned IRQ_W = 3;

    // ==========================================================
    // Reset values
    localparam logic [15:0] CTRL_RESET = 16'h0000;
    localparam logic [1:0] CMD_RESET = 2'h0;
    localparam logic [31:0] BASE_RESET = 32'hFFFF_FFFF;
    localparam logic [31:0] LIMIT_RESET = 32'h0000_0000;
    localparam logic [IRQ_W-1:0] IRQ_RESET = 3'h0;

    // ==========================================================
    // Legacy display address ranges
    localparam logic [31:0] VGA_MEM_LO = 32'h000A_0000;
    localparam logic [31:0] VGA_MEM_HI = 32'h000B_FFFF;
    localparam logic [9:0] VGA_IO_A_LO = 10'h3B0;
    localparam logic [9:0] VGA_IO_A_HI = 10'h3BB;
    localparam logic [9:0] VGA_IO_B_LO = 10'h3C0;
    localparam logic [9:0] VGA_IO_B_HI = 10'h3DF;

    // ==========================================================
    // Answers and bus word size
    localparam logic [31:0] ALL_ONES = 32'hFFFF_FFFF;
    localparam logic [2:0] CPL_SC = 3'h0;
    localparam logic [2:0] CPL_UR = 3'h1;
    localparam logic [2:0] HSIZE_WORD = 3'h2;

endpackage

`default_nettype wire

// *** core/legacy_display_decode.sv ***
// Legacy display address match for one side of the bridge.
// Assumes the caller gates the result with the forward enable.
`default_nettype none

module legacy_display_decode (
    input wire logic [31:0] addr,
    input wire logic full_io_decode,
    output logic mem_hit,
    output logic io_hit
);

    // ==========================================================
    // Address match
    logic [9:0] low;
    logic in_range;
    logic alias_ok;

    // Memory window is fixed; I/O checks the low ten bits plus alias policy
    always_comb begin
        low = addr[9:0];
        mem_hit = (addr >= bridge_pkg::VGA_MEM_LO) && (addr <= bridge_pkg::VGA_MEM_HI);
        in_range = ((low >= bridge_pkg::VGA_IO_A_LO) && (low <= bridge_pkg::VGA_IO_A_HI))
            || ((low >= bridge_pkg::VGA_IO_B_LO) && (low <= bridge_pkg::VGA_IO_B_HI)); // see R8
        alias_ok = !full_io_decode || (addr[15:10] == 6'h00); // see R6
        io_hit = (addr[31:16] == 16'h0000) && in_range && alias_ok; // see R8
    end

endmodule // legacy_display_decode

`default_nettype wire

// *** tb/pci_far_model.sv ***
// Far-side model: PCI Express and PCI parties raising requests and events.
// Assumes the bench calls its tasks; every change follows a rising edge.
`default_nettype none
module pci_far_model (
    input wire logic hclk,
    output logic req_valid,
    output logic req_io,
    output logic [31:0] req_addr,
    output logic ma_valid,
    output logic ur_valid,
    output logic ev_read,
    output logic ev_posted
);
    timeunit 1ns;
    timeprecision 1ps;
    // ==========
    // Idle values at time zero
    initial begin
        {req_valid, req_io, ma_valid, ur_valid, ev_read, ev_posted} = 6'h00;
        req_addr = 32'h0000_0000;
    end
    // One-cycle request to both sides; address inverted after, never looks held
    task automatic req(input logic io, input logic [31:0] a);
        @(posedge hclk);
        req_valid <= 1'h1;
        req_io <= io;
        req_addr <= a;
        @(posedge hclk);
        req_valid <= 1'h0;
        req_addr <= ~a;
    endtask
    // Master abort on PCI (ur low) or unsupported completion from PCIe
    task automatic ev(input logic ur, input logic rdx, input logic posted);
        @(posedge hclk);
        ma_valid <= !ur;
        ur_valid <= ur;
        ev_read <= rdx;
        ev_posted <= posted;
        @(posedge hclk);
        ma_valid <= 1'h0;
        ur_valid <= 1'h0;
    endtask
endmodule // pci_far_model
`default_nettype wire

// *** tb/tb_bridge_abort_and_legacy_display_decode.sv ***
// Bench: abort answers and legacy display decode, registers over AHB-Lite.
// Assumes one bus slave and the far-side model raising requests and events.
`default_nettype none
module tb_bridge_abort_and_legacy_display_decode;
    timeunit 1ns;
    timeprecision 1ps;
    // ==========
    // Bus master state, settled at time zero
    logic hclk = 1'h0;
    logic hresetn = 1'h0;
    logic hsel = 1'h0;
    logic hwrite = 1'h0;
    logic [1:0] htrans = 2'h0;
    logic [31:0] haddr = 32'h0000_0000;
    logic [31:0] hwdata = 32'h0000_0000;
    logic [31:0] rd;
    int mismatches = 0;
    int checks_done = 0;
    wire logic [31:0] hrdata, cpl_data, pci_rdata, req_addr;
    wire logic [2:0] cpl_status;
    wire logic hreadyout, hresp, pri_fwd_valid, pri_fwd_claim, sec_fwd_valid, sec_fwd_up;
    wire logic cpl_valid, posted_err, pci_term_valid, pci_target_abort, irq;
    wire logic req_valid, req_io, ma_valid, ur_valid, ev_read, ev_posted;
    // Both sides share one request stream; one slave, so hready is hreadyout
    bridge_abort_ctrl u_dut (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(bridge_pkg::HSIZE_WORD), .hwdata(hwdata),
        .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
        .pri_req_valid(req_valid), .pri_req_io(req_io), .pri_req_addr(req_addr),
        .pri_fwd_valid(pri_fwd_valid), .pri_fwd_claim(pri_fwd_claim),
        .sec_req_valid(req_valid), .sec_req_io(req_io), .sec_req_addr(req_addr),
        .sec_fwd_valid(sec_fwd_valid), .sec_fwd_up(sec_fwd_up), .ma_valid(ma_valid),
        .ma_read(ev_read), .ma_posted(ev_posted), .cpl_valid(cpl_valid),
        .cpl_status(cpl_status), .cpl_data(cpl_data), .posted_err(posted_err),
        .ur_valid(ur_valid), .ur_read(ev_read), .pci_term_valid(pci_term_valid),
        .pci_target_abort(pci_target_abort), .pci_rdata(pci_rdata), .irq(irq));
    pci_far_model u_far (.hclk(hclk), .req_valid(req_valid), .req_io(req_io),
        .req_addr(req_addr), .ma_valid(ma_valid), .ur_valid(ur_valid),
        .ev_read(ev_read), .ev_posted(ev_posted));
    // ==========
    // Clock, reset and run order
    always #5 hclk = !hclk;
    initial begin
        repeat (20) @(posedge hclk);
        hresetn <= 1'h1;
        t_regs();
        t_decode();
        t_window();
        t_abort();
        give_verdict();
    end
    // Watchdog at 10000 cycles, well past the few hundred cycles the run needs
    initial begin
        #100000;
        mismatches++;
        give_verdict();
    end
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        checks_done++;
        if (g !== e) begin
            mismatches++;
            $display("[FAIL] %s expected %h seen %h", n, e, g);
        end
    endtask
    // Single word transfer; waits on hready at each phase, no fixed latency
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge hclk);
        hsel <= 1'h1;
        htrans <= 2'h2;
        hwrite <= w;
        haddr <= {24'h00_0000, a};
        do @(posedge hclk); while (hreadyout !== 1'h1);
        hsel <= 1'h0;
        htrans <= 2'h0;
        haddr <= ~haddr;
        hwdata <= d;
        do @(posedge hclk); while (hreadyout !== 1'h1);
        rd = hrdata;
    endtask
    task automatic rdc(input string n, input logic [7:0] a, input logic [31:0] e);
        bus(1'h0, a, 32'h0000_0000);
        chk(n, e, rd);
    endtask
    // Legacy display match worked out independently of the design
    function automatic logic hit(input logic io, input logic full, input logic [31:0] a);
        if (!io)
            return a >= 32'h000A_0000 && a <= 32'h000B_FFFF;
        return a[31:16] == 16'h0000 && !(full && a[15:10] != 6'h00) &&
            ((a[9:0] >= 10'h3B0 && a[9:0] <= 10'h3BB) || (a[9:0] >= 10'h3C0 && a[9:0] <= 10'h3DF));
    endfunction
    // ==========
    // Scenarios
    task automatic t_regs();
        rdc("ctrl_reset", 8'h00, 32'h0000_0000);
        rdc("io_base_reset", 8'h08, 32'hFFFF_FFFF);
        chk("hresp_okay", 32'h0000_0000, hresp);
        bus(1'h1, 8'h30, 32'h1234_5678);
        rdc("unmapped", 8'h30, 32'h0000_0000);
        bus(1'h1, 8'h00, 32'h0000_0038);
        rdc("ctrl_rw", 8'h00, 32'h0000_0038);
        $display("test regs done");
    endtask
    // Every forward and full decode mix and command enable over range edges and aliases
    task automatic t_decode();
        logic [31:0] ad [12] = '{32'h0009_FFFF, 32'h000A_0000, 32'h000B_FFFF, 32'h000C_0000,
            32'h0000_03AF, 32'h0000_03B0, 32'h0000_03BB, 32'h0000_03BC, 32'h0000_03DF,
            32'h0000_03E0, 32'h0000_FFC0, 32'h0001_03C0};
        logic [7:0] cv [4] = '{8'h04, 8'h0C, 8'h1C, 8'h10};
        logic h;
        for (int c = 0; c < 4; c++) begin
            bus(1'h1, 8'h00, {24'h00_0000, cv[c]});
            for (int e = 0; e < 4; e++) begin
                bus(1'h1, 8'h04, 32'(e));
                for (int i = 0; i < 12; i++) begin
                    h = cv[c][3] && hit(i > 3, cv[c][4], ad[i]);
                    u_far.req(i > 3, ad[i]);
                    #1;
                    chk("claim", (i > 3 ? e[0] : e[1]) && h, pri_fwd_claim);
                    chk("upstream", !h, sec_fwd_up);
                    chk("fwd_valid", 1'h1, pri_fwd_valid && sec_fwd_valid);
                end
            end
        end
        $display("test decode done");
    endtask
    task automatic t_window();
        bus(1'h1, 8'h00, 32'h0000_0000);
        bus(1'h1, 8'h10, 32'h000A_0000);
        bus(1'h1, 8'h14, 32'h000A_0FFF);
        u_far.req(1'h0, 32'h000A_0800);
        #1;
        chk("win_claim", 1'h1, pri_fwd_claim);
        u_far.req(1'h0, 32'h000B_0000);
        #1;
        chk("out_claim", 1'h0, pri_fwd_claim);
        bus(1'h1, 8'h00, 32'h0000_0008);
        u_far.req(1'h0, 32'h000B_0000);
        #1;
        chk("legacy_claim", 1'h1, pri_fwd_claim);
        $display("test window done");
    endtask
    // Both answer modes, then the interrupt raised, masked and cleared
    task automatic t_abort();
        for (int m = 0; m < 2; m++) begin
            bus(1'h1, 8'h00, m ? 32'h0000_0020 : 32'h0000_0000);
            u_far.ev(1'h0, 1'h1, 1'h0);
            #1;
            chk("cpl_valid", 1'h1, cpl_valid);
            chk("cpl_status", m ? bridge_pkg::CPL_UR : bridge_pkg::CPL_SC, cpl_status);
            chk("cpl_data", m ? 32'h0000_0000 : 32'hFFFF_FFFF, cpl_data);
            u_far.ev(1'h0, 1'h0, 1'h1);
            #1;
            chk("posted_cpl", 1'h0, cpl_valid);
            chk("posted_err", m[0], posted_err);
            u_far.ev(1'h1, 1'h1, 1'h0);
            #1;
            chk("term_valid", 1'h1, pci_term_valid);
            chk("target_abort", m[0], pci_target_abort);
            chk("pci_rdata", m ? 32'h0000_0000 : 32'hFFFF_FFFF, pci_rdata);
        end
        chk("irq_masked", 1'h0, irq);
        rdc("irq_stat", 8'h20, 32'h0000_0007);
        rdc("irq_cleared", 8'h20, 32'h0000_0000);
        bus(1'h1, 8'h24, 32'h0000_0001);
        u_far.ev(1'h0, 1'h0, 1'h1);
        @(posedge hclk);
        #1;
        chk("irq_set", 1'h1, irq);
        rdc("irq_stat_one", 8'h20, 32'h0000_0001);
        @(posedge hclk);
        #1;
        chk("irq_low", 1'h0, irq);
        $display("test abort done");
    endtask
endmodule // tb_bridge_abort_and_legacy_display_decode
`default_nettype wire
